// ### logic/pds_top.sv
// positioning record table, start selection, chaining and motion profile
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "pds_params.svh"
module pds_top #(
  parameter int unsigned CYC_PER_MS = `PDS_MS_NS / `PDS_CLK_PERIOD_NS,
  parameter int unsigned STEP_DEN   = `PDS_STEP_RPM_DEN * (`PDS_S_NS / `PDS_CLK_PERIOD_NS)
)(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               record_select_bit0,
  input  wire logic               record_select_bit1,
  input  wire logic               record_select_bit2,
  input  wire logic               record_select_bit3,
  input  wire logic               start,
  input  wire logic               direct_start_line0,
  input  wire logic               direct_start_line1,
  input  wire logic               direct_start_line2,
  input  wire logic               direct_start_line3,
  input  wire logic               direct_start_line4,
  input  wire logic               direct_start_line5,
  input  wire logic               step_start,
  input  wire logic               record_invalidate,
  output logic                    ready,
  output logic                    step_pulse,
  output logic                    step_dir,
  output logic      [11:0]        cmd_speed,
  output logic      [8:0]         torque_limit,
  output logic      [7:0]         present_record,
  output logic      [31:0]        position
);
  localparam pds_pkg::pds_state_t st_idle  = pds_pkg::st_idle;
  localparam pds_pkg::pds_state_t st_run   = pds_pkg::st_run;
  localparam pds_pkg::pds_state_t st_dwell = pds_pkg::st_dwell;
  pds_pkg::pds_record_t rec_q [16];
  pds_pkg::pds_record_t cur_rec;
  pds_pkg::pds_state_t  state_q;
  logic [23:0] dmap_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [7:0]  in_q;
  logic [7:0]  in_now;
  logic [7:0]  rise;
  logic [3:0]  sel_num;
  logic        go;
  logic        go_seq;
  logic [3:0]  go_num;
  logic [3:0]  step_num;
  logic [3:0]  seq_start_q;
  logic        valid_q;
  logic [3:0]  cur_q;
  logic signed [31:0] dest_q;
  logic signed [31:0] pos_q;
  logic [11:0] spd_q;
  logic [31:0] racc_q;
  logic [31:0] pacc_q;
  logic        step_q;
  logic        dir_q;
  logic        ready_q;
  logic [31:0] cyc_q;
  logic [15:0] dms_q;
  logic        fwd;
  logic [31:0] rem;
  logic [11:0] goal;
  logic        brake;
  logic [31:0] ramp_lim;
  logic [31:0] ramp_sum;
  logic [31:0] pacc_sum;
  logic        inv;
  logic        apb_wr;
  logic        rec_hit;

  function automatic logic [31:0] ms_cycles(input logic [15:0] ms);
    return 32'(ms) * 32'(CYC_PER_MS);
  endfunction

  function automatic logic signed [31:0] dest_of(input pds_pkg::pds_record_t r,
                                                 input logic signed [31:0] base);
    logic signed [31:0] t;
    t = 32'(r.target);
    if (r.mode == `PDS_MODE_ABS)
      return t;
    return base + t;
  endfunction

  function automatic logic [31:0] rec_read(input pds_pkg::pds_record_t r, input logic [1:0] w);
    unique case (w)
      2'h0: return 32'(r.target);
      2'h1: return {7'h00, r.chain, 2'h0, r.func, 3'h0, r.mode, 4'h0, r.speed};
      2'h2: return {1'h0, r.decel, 1'h0, r.accel};
      2'h3: return {r.dwell, 7'h00, r.torque};
    endcase
  endfunction

  function automatic pds_pkg::pds_record_t rec_write(input pds_pkg::pds_record_t r,
                                                     input logic [1:0] w,
                                                     input logic [31:0] d);
    pds_pkg::pds_record_t n;
    n = r;
    unique case (w)
      2'h0: n.target = d[23:0];
      2'h1:
      begin
        n.speed = (d[11:0] > `PDS_SPEED_MAX) ? `PDS_SPEED_MAX : d[11:0];
        n.mode  = d[16];
        n.func  = (d[21:20] > `PDS_FUNC_DWELL) ? `PDS_FUNC_SINGLE : d[21:20];
        n.chain = d[24];
      end
      2'h2:
      begin
        n.accel = (d[14:0] > `PDS_RAMP_MAX_MS) ? `PDS_RAMP_MAX_MS : d[14:0];
        n.decel = (d[30:16] > `PDS_RAMP_MAX_MS) ? `PDS_RAMP_MAX_MS : d[30:16];
      end
      2'h3:
      begin
        n.torque = d[8:0];
        n.dwell  = (d[31:16] > `PDS_DWELL_MAX_MS) ? `PDS_DWELL_MAX_MS : d[31:16];
      end
    endcase
    return n;
  endfunction

  // apb slave, zero wait states, read data captured in the setup cycle
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
  assign apb_wr  = psel & penable & pwrite;
  assign rec_hit = (paddr[11:8] == `PDS_REC_PAGE);
  assign inv     = record_invalidate | (apb_wr & (paddr == `PDS_OFS_CONTROL) & pwdata[0]);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (psel & ~penable)
    begin
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (rec_hit)
        prdata_q <= rec_read(rec_q[paddr[7:4]], paddr[3:2]);
      else
        unique case (paddr)
          `PDS_OFS_STATUS:   prdata_q <= {12'h000, seq_start_q, present_record,
                                          4'h0, 2'(state_q), valid_q, ready_q};
          `PDS_OFS_CONTROL:  prdata_q <= 32'h0000_0000;
          `PDS_OFS_DMAP:     prdata_q <= {8'h00, dmap_q};
          `PDS_OFS_POSITION: prdata_q <= pos_q;
          `PDS_OFS_ANGLE:    prdata_q <= pos_q * `PDS_ANGLE_CDEG;
          `PDS_OFS_SPEED:    prdata_q <= {20'h00000, spd_q};
          default:           pslverr_q <= 1'b1;
        endcase
    end

  // record table and direct start map
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      dmap_q <= `PDS_DMAP_RST;
      for (int i = 0; i < 16; i++)
      begin
        rec_q[i]        <= '0;
        rec_q[i].accel  <= `PDS_ACCEL_RST;
        rec_q[i].decel  <= `PDS_DECEL_RST;
        rec_q[i].torque <= `PDS_TORQUE_RST;
      end
    end
    else if (apb_wr)
    begin
      if (rec_hit)
        rec_q[paddr[7:4]] <= rec_write(rec_q[paddr[7:4]], paddr[3:2], pwdata);
      else if (paddr == `PDS_OFS_DMAP)
        dmap_q <= pwdata[23:0];
    end

  // start line edges and selection
  assign sel_num = {record_select_bit3, record_select_bit2,
                    record_select_bit1, record_select_bit0};
  assign in_now  = {step_start, direct_start_line5, direct_start_line4, direct_start_line3,
                    direct_start_line2, direct_start_line1, direct_start_line0, start};
  assign rise    = in_now & ~in_q;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      in_q <= 8'h00;
    else
      in_q <= in_now;

  always_comb
  begin
    step_num = cur_q + 4'h1;
    if (!valid_q || !rec_q[step_num].chain)
      step_num = seq_start_q;
  end

  always_comb
  begin
    go     = 1'b0;
    go_seq = 1'b0;
    go_num = 4'h0;
    if (ready_q && !inv)
    begin
      if (rise[0])
      begin
        go     = 1'b1;
        go_seq = 1'b1;
        go_num = sel_num;
      end
      else
      begin
        for (int i = 5; i >= 0; i--)
          if (rise[i+1])
          begin
            go     = 1'b1;
            go_seq = 1'b1;
            go_num = dmap_q[4*i +: 4];
          end
        if (!go && rise[7])
        begin
          go     = 1'b1;
          go_num = step_num;
        end
      end
    end
  end

  // chaining start point and present record validity
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      seq_start_q <= 4'h0;
      valid_q     <= 1'b0;
    end
    else if (inv)
    begin
      seq_start_q <= 4'h0;
      valid_q     <= 1'b0;
    end
    else if (go)
    begin
      valid_q <= 1'b1;
      if (go_seq)
        seq_start_q <= go_num;
    end

  // motion profile
  assign cur_rec  = rec_q[cur_q];
  assign fwd      = dest_q > pos_q;
  assign rem      = fwd ? 32'(dest_q - pos_q) : 32'(pos_q - dest_q);
  assign brake    = (cur_rec.func != `PDS_FUNC_LINK) &&
                    (64'(rem) * `PDS_BRAKE_K <= 64'(spd_q) * 64'(spd_q) * 64'(cur_rec.decel));
  assign goal     = brake ? 12'h001 : ((cur_rec.speed == 12'h000) ? 12'h001 : cur_rec.speed);
  assign ramp_lim = ms_cycles({1'b0, (spd_q < goal) ? cur_rec.accel : cur_rec.decel});
  assign ramp_sum = racc_q + `PDS_RAMP_REF_RPM;
  assign pacc_sum = pacc_q + 32'(spd_q) * `PDS_STEP_RPM_NUM;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state_q <= st_idle;
      cur_q   <= 4'h0;
      dest_q  <= 32'sh0;
      pos_q   <= 32'sh0;
      spd_q   <= 12'h000;
      racc_q  <= 32'h0;
      pacc_q  <= 32'h0;
      step_q  <= 1'b0;
      dir_q   <= 1'b0;
      ready_q <= 1'b1;
      cyc_q   <= 32'h0;
      dms_q   <= 16'h0;
    end
    else
    begin
      step_q <= 1'b0;
      if (inv)
      begin
        state_q <= st_idle;
        spd_q   <= 12'h000;
        ready_q <= 1'b1;
      end
      else
        unique case (state_q)
          st_idle:
            if (go)
            begin
              cur_q   <= go_num;
              dest_q  <= dest_of(rec_q[go_num], pos_q);
              ready_q <= 1'b0;
              racc_q  <= 32'h0;
              pacc_q  <= 32'h0;
              state_q <= st_run;
            end
          st_run:
            if (rem == 32'h0)
            begin
              racc_q <= 32'h0;
              if (cur_rec.func == `PDS_FUNC_LINK)
              begin
                cur_q  <= cur_q + 4'h1;
                dest_q <= dest_of(rec_q[cur_q + 4'h1], pos_q);
              end
              else if (cur_rec.func == `PDS_FUNC_DWELL)
              begin
                spd_q   <= 12'h000;
                cyc_q   <= 32'h0;
                dms_q   <= 16'h0;
                state_q <= st_dwell;
              end
              else
              begin
                spd_q   <= 12'h000;
                ready_q <= 1'b1;
                state_q <= st_idle;
              end
            end
            else
            begin
              if (spd_q != goal)
              begin
                if (ramp_lim == 32'h0)
                  spd_q <= goal;
                else if (ramp_sum >= ramp_lim)
                begin
                  racc_q <= ramp_sum - ramp_lim;
                  spd_q  <= (spd_q < goal) ? spd_q + 12'h001 : spd_q - 12'h001;
                end
                else
                  racc_q <= ramp_sum;
              end
              if (pacc_sum >= 32'(STEP_DEN))
              begin
                pacc_q <= pacc_sum - 32'(STEP_DEN);
                step_q <= 1'b1;
                dir_q  <= fwd;
                pos_q  <= fwd ? pos_q + 32'sh1 : pos_q - 32'sh1;
              end
              else
                pacc_q <= pacc_sum;
            end
          st_dwell:
            if (dms_q >= cur_rec.dwell)
            begin
              cur_q   <= cur_q + 4'h1;
              dest_q  <= dest_of(rec_q[cur_q + 4'h1], pos_q);
              racc_q  <= 32'h0;
              pacc_q  <= 32'h0;
              state_q <= st_run;
            end
            else if (cyc_q == 32'(CYC_PER_MS - 1))
            begin
              cyc_q <= 32'h0;
              dms_q <= dms_q + 16'h1;
            end
            else
              cyc_q <= cyc_q + 32'h1;
          default: state_q <= st_idle;
        endcase
    end

  assign ready          = ready_q;
  assign step_pulse     = step_q;
  assign step_dir       = dir_q;
  assign cmd_speed      = spd_q;
  assign torque_limit   = cur_rec.torque;
  assign present_record = valid_q ? {4'h0, cur_q} : `PDS_NO_RECORD;
  assign position       = pos_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence run_end_s;
    state_q == st_run && rem == 32'h0 && !inv;
  endsequence

  ready_drop_a: assert property (go |=> !ready_q)
    else $error("ready did not drop at start");
  busy_ignore_a: assert property (!ready_q && rise != 8'h00 && state_q == st_run
                                  && rem != 32'h0 && !inv |=> $stable(cur_q))
    else $error("start taken while busy");
  select_run_a: assert property (ready_q && rise[0] && !inv |=> cur_q == $past(sel_num)
                                 && state_q == st_run)
    else $error("select start ran wrong record");
  direct_run_a: assert property (ready_q && rise[1:0] == 2'b10 && !inv
                                 |=> cur_q == $past(dmap_q[3:0]))
    else $error("direct start ran wrong record");
  step_run_a: assert property (ready_q && rise[6:0] == 7'h00 && rise[7] && !inv
                               |=> cur_q == $past(step_num))
    else $error("step start ran wrong record");
  invalid_rst_a: assert property (inv |=> seq_start_q == 4'h0
                                  && present_record == `PDS_NO_RECORD)
    else $error("invalidation not applied");
  single_stop_a: assert property (run_end_s and cur_rec.func == `PDS_FUNC_SINGLE
                                  |=> state_q == st_idle && ready_q && spd_q == 12'h000)
    else $error("single move did not stop");
  linked_go_a: assert property (run_end_s and cur_rec.func == `PDS_FUNC_LINK
                                |=> cur_q == $past(cur_q) + 4'h1 && state_q == st_run)
    else $error("linked move did not continue");
  dwell_hold_a: assert property (run_end_s and cur_rec.func == `PDS_FUNC_DWELL
                                 |=> state_q == st_dwell && spd_q == 12'h000 && !ready_q)
    else $error("dwell move did not pause");
  step_pos_a: assert property (step_q |-> pos_q == $past(pos_q) + (dir_q ? 32'sh1 : -32'sh1))
    else $error("position does not follow step");
  latch_sel_a: assert property (state_q == st_run && rem != 32'h0 && !inv
                                |=> $stable(cur_q) && $stable(dest_q))
    else $error("record changed during move");
  speed_cap_a: assert property (spd_q <= `PDS_SPEED_MAX)
    else $error("commanded speed above limit");
endmodule

// ### logic/pds_params.svh
// constants for the positioning record store and start selection
`ifndef PDS_PARAMS_SVH
`define PDS_PARAMS_SVH
`define PDS_CLK_PERIOD_NS 10
`define PDS_MS_NS         1000000
`define PDS_S_NS          1000000000
`define PDS_STEP_RPM_NUM  32'h19
`define PDS_STEP_RPM_DEN  3
`define PDS_BRAKE_K       64'hAFC80
`define PDS_RAMP_REF_RPM  32'hBB8
`define PDS_SPEED_MAX     12'hFA0
`define PDS_RAMP_MAX_MS   15'h7530
`define PDS_DWELL_MAX_MS  16'hC350
`define PDS_ANGLE_CDEG    32'h48
`define PDS_TORQUE_RST    9'h0FA
`define PDS_ACCEL_RST     15'h0064
`define PDS_DECEL_RST     15'h0064
`define PDS_DMAP_RST      24'h543210
`define PDS_FUNC_SINGLE   2'h0
`define PDS_FUNC_LINK     2'h1
`define PDS_FUNC_DWELL    2'h2
`define PDS_MODE_ABS      1'h1
`define PDS_NO_RECORD     8'hFF
`define PDS_OFS_STATUS    12'h000
`define PDS_OFS_CONTROL   12'h004
`define PDS_OFS_DMAP      12'h008
`define PDS_OFS_POSITION  12'h00C
`define PDS_OFS_ANGLE     12'h010
`define PDS_OFS_SPEED     12'h014
`define PDS_REC_PAGE      4'h1
`endif

// ### logic/pds_pkg.sv
// types for the positioning record store and start selection
package pds_pkg;
  typedef struct packed {
    logic signed [23:0] target;
    logic [11:0]        speed;
    logic               mode;
    logic [1:0]         func;
    logic [14:0]        accel;
    logic [14:0]        decel;
    logic [8:0]         torque;
    logic               chain;
    logic [15:0]        dwell;
  } pds_record_t;
  typedef enum logic [1:0] {st_idle, st_run, st_dwell} pds_state_t;
endpackage

// ### verif/pds_host_model.sv
// host controller model driving the record select and start lines
`timescale 1ns/1ns
module pds_host_model #(
  parameter int unsigned CYC_PER_MS = 10
)(
  input  wire logic pclk,
  input  wire logic ready,
  output logic      record_select_bit0,
  output logic      record_select_bit1,
  output logic      record_select_bit2,
  output logic      record_select_bit3,
  output logic      start,
  output logic      direct_start_line0,
  output logic      direct_start_line1,
  output logic      direct_start_line2,
  output logic      direct_start_line3,
  output logic      direct_start_line4,
  output logic      direct_start_line5,
  output logic      step_start
);
  logic [3:0] sel_q = 4'h0;
  logic [5:0] dsl_q = 6'h00;
  logic       start_q = 1'b0;
  logic       step_q = 1'b0;
  assign {record_select_bit3, record_select_bit2, record_select_bit1, record_select_bit0} = sel_q;
  assign {direct_start_line5, direct_start_line4, direct_start_line3} = dsl_q[5:3];
  assign {direct_start_line2, direct_start_line1, direct_start_line0} = dsl_q[2:0];
  assign start = start_q;
  assign step_start = step_q;

  // kind 0 start, 1 direct line, 2 step start
  task automatic drive(input int kind, input logic [3:0] num, input logic v);
    case (kind)
      0: start_q <= v;
      1: dsl_q[num[2:0]] <= v;
      default: step_q <= v;
    endcase
  endtask

  task automatic wait_ready(input logic want, output bit ok);
    int n;
    n = 0;
    while (ready !== want && n < 5000)
    begin
      @(posedge pclk);
      n++;
    end
    ok = (ready === want);
  endtask

  task automatic start_move(input int kind, input logic [3:0] num, output bit ok);
    bit ok2;
    wait_ready(1'b1, ok);
    @(posedge pclk);
    sel_q <= num;
    repeat (10 * CYC_PER_MS) @(posedge pclk);
    drive(kind, num, 1'b1);
    wait_ready(1'b0, ok2);
    drive(kind, num, 1'b0);
    ok = ok & ok2;
  endtask

  // start attempt while busy, select settle time not honoured
  task automatic pulse(input int kind, input logic [3:0] num);
    @(posedge pclk);
    sel_q <= num;
    @(posedge pclk);
    drive(kind, num, 1'b1);
    @(posedge pclk);
    drive(kind, num, 1'b0);
  endtask
endmodule

// ### verif/positioning_data_start_select_tb_top.sv
// testbench for the positioning record store and start selection
`timescale 1ns/1ns
module positioning_data_start_select_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, position, rd;
  logic        record_select_bit0, record_select_bit1, record_select_bit2, record_select_bit3;
  logic        start, step_start, record_invalidate, ready, step_pulse, step_dir, er;
  logic        direct_start_line0, direct_start_line1, direct_start_line2;
  logic        direct_start_line3, direct_start_line4, direct_start_line5;
  logic [11:0] cmd_speed;
  logic [8:0]  torque_limit;
  logic [7:0]  present_record;
  int          failures, n_checks;
  int          n_steps;
  bit          ok;

  pds_top #(.CYC_PER_MS(10), .STEP_DEN(3000)) pds_top_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .record_select_bit0, .record_select_bit1, .record_select_bit2,
    .record_select_bit3, .start, .direct_start_line0, .direct_start_line1,
    .direct_start_line2, .direct_start_line3, .direct_start_line4, .direct_start_line5,
    .step_start, .record_invalidate, .ready, .step_pulse, .step_dir, .cmd_speed,
    .torque_limit, .present_record, .position);

  pds_host_model #(.CYC_PER_MS(10)) pds_host_model_i (
    .pclk, .ready, .record_select_bit0, .record_select_bit1, .record_select_bit2,
    .record_select_bit3, .start, .direct_start_line0, .direct_start_line1,
    .direct_start_line2, .direct_start_line3, .direct_start_line4, .direct_start_line5,
    .step_start);

  always #5 pclk = ~pclk;

  // counts step pulses seen on the stepping output
  always @(posedge pclk)
    if (step_pulse === 1'b1)
      n_steps++;

  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic guard(input bit good);
    if (!good)
    begin
      failures++;
      complete_run();
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    guard(pready === 1'b1);
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  function automatic logic [11:0] ra(input int n, input int w);
    return 12'h100 | (12'(n) << 4) | (12'(w) << 2);
  endfunction

  // speed fixed at 120 r/min, one step per clock with the short step divider
  function automatic logic [31:0] w1(input logic mode, input logic [1:0] fn, input logic ch);
    return {7'h00, ch, 2'h0, fn, 3'h0, mode, 4'h0, 12'h078};
  endfunction

  task automatic wrec(input int n, input logic [31:0] t, input logic [31:0] c, input logic [31:0] e);
    apb(1'b1, ra(n, 0), t);
    apb(1'b1, ra(n, 1), c);
    apb(1'b1, ra(n, 2), 32'h0);
    apb(1'b1, ra(n, 3), e);
  endtask

  task automatic fin(input logic [7:0] rec, input logic [31:0] pos);
    pds_host_model_i.wait_ready(1'b1, ok);
    guard(ok);
    chk("present_record", {24'h0, rec}, {24'h0, present_record});
    chk("position", pos, position);
  endtask

  task automatic mv(input int kind, input logic [3:0] num, input logic [7:0] rec, input int pos);
    pds_host_model_i.start_move(kind, num, ok);
    guard(ok);
    fin(rec, pos);
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    record_invalidate = 1'b0;
    failures = 0;
    n_checks = 0;
    n_steps = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("ready", 32'h1, {31'h0, ready});
    chk("present_record", 32'hFF, {24'h0, present_record});
    chk("torque_limit", 32'hFA, {23'h0, torque_limit});
    for (int n = 0; n < 16; n += 15)
    begin
      rdchk("target", ra(n, 0), 32'h0);
      rdchk("speed mode func chain", ra(n, 1), 32'h0);
      rdchk("ramps", ra(n, 2), 32'h00640064);
      rdchk("torque dwell", ra(n, 3), 32'h000000FA);
    end
    rdchk("direct map", 12'h008, 32'h00543210);
    rdchk("unmapped", 12'h080, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    apb(1'b1, ra(15, 1), 32'h00000FFF);
    rdchk("speed clamp", ra(15, 1), 32'h00000FA0);
    wrec(0, 32'd5, w1(1'b0, 2'h0, 1'b1), 32'hFA);
    wrec(1, 32'd3, w1(1'b0, 2'h0, 1'b1), 32'hFA);
    wrec(2, 32'd20, w1(1'b1, 2'h0, 1'b1), 32'hFA);
    wrec(3, 32'd7, w1(1'b0, 2'h0, 1'b0), 32'hFA);
    wrec(4, 32'd200, w1(1'b0, 2'h0, 1'b0), 32'h50);
    wrec(5, 32'd4, w1(1'b0, 2'h1, 1'b0), 32'hFA);
    wrec(6, 32'd6, w1(1'b0, 2'h0, 1'b0), 32'hFA);
    wrec(7, 32'd3, w1(1'b0, 2'h2, 1'b0), 32'h000100FA);
    wrec(8, -32'sd3, w1(1'b0, 2'h0, 1'b0), 32'hFA);
    mv(0, 4'h0, 8'h00, 5);
    chk("step_pulse count", 32'd5, n_steps);
    mv(2, 4'h0, 8'h01, 8);
    mv(2, 4'h0, 8'h02, 20);
    mv(2, 4'h0, 8'h00, 25);
    mv(1, 4'h1, 8'h01, 28);
    pds_host_model_i.start_move(0, 4'h4, ok);
    guard(ok);
    pds_host_model_i.pulse(0, 4'h0);
    chk("ready", 32'h0, {31'h0, ready});
    chk("cmd_speed", 32'h78, {20'h0, cmd_speed});
    chk("torque_limit", 32'h50, {23'h0, torque_limit});
    fin(8'h04, 228);
    chk("cmd_speed", 32'h0, {20'h0, cmd_speed});
    mv(0, 4'h5, 8'h06, 238);
    mv(0, 4'h7, 8'h08, 238);
    chk("step_dir", 32'h0, {31'h0, step_dir});
    rdchk("angle", 12'h010, 32'd17136);
    rdchk("position", 12'h00C, 32'd238);
    apb(1'b1, 12'h004, 32'h1);
    @(posedge pclk);
    chk("present_record", 32'hFF, {24'h0, present_record});
    mv(2, 4'h0, 8'h00, 243);
    @(posedge pclk);
    record_invalidate <= 1'b1;
    @(posedge pclk);
    record_invalidate <= 1'b0;
    @(posedge pclk);
    chk("present_record", 32'hFF, {24'h0, present_record});
    complete_run();
  end
endmodule
